/* src/term_io_pkg.sv */
// package: constants and types for the terminal i/o controller
package term_io_pkg;
	localparam int CLK_HZ          = 25_000_000;
	localparam int KEY_SETTLE_NS   = 6000;
	localparam int KEY_SETTLE_CYC  =
		(KEY_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int DMA_WARN_NS     = 9000;
	localparam int DMA_WARN_CYC    = DMA_WARN_NS * (CLK_HZ / 1_000_000) / 1000;
	localparam int BUS_PHASE_CYC   = 2;
	localparam int KEY_ROWS        = 13;
	localparam int KEY_COLS        = 8;
	localparam int KEY_COUNT       = KEY_ROWS * KEY_COLS;
	localparam int DEBOUNCE_CNT    = 4;
	localparam int NVM_HALF_CYC    = 64;
	localparam logic [7:0] RST_ADDR_HI = 8'h00;

	typedef enum logic [1:0]
	{
		SP_IDLE  = 2'h0,
		SP_ADDR  = 2'h1,
		SP_DATA  = 2'h3,
		SP_END   = 2'h2
	} space_t;

	typedef struct packed
	{
		logic       valid;
		logic       write;
		space_t     space;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed
	{
		logic       cmd;
		logic       sda_out;
		logic       sda_oe;
		logic       scl;
	} serial_pins_t;
endpackage

/* src/key_scanner.sv */
// key matrix walker with settle wait and per-key debounce
module key_scanner #(
	parameter int KEYS  = term_io_pkg::KEY_COUNT,
	parameter int WAIT  = term_io_pkg::KEY_SETTLE_CYC,
	parameter int DEB   = term_io_pkg::DEBOUNCE_CNT
)(
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	// scanner link
	output logic                         kbd_cmd,
	input  wire logic                    kbd_ret,
	// key events
	output logic                         key_event,
	output logic                         key_down,
	output logic [6:0]                   key_addr
);
	logic [6:0]          addr;
	logic [6:0]          next_addr;
	logic [15:0]         wait_cnt;
	logic [15:0]         next_wait_cnt;
	logic                cmd;
	logic                next_cmd;
	logic [KEYS-1:0]     state;
	logic [KEYS-1:0]     next_state;
	logic [2:0]          deb [KEYS];
	logic [2:0]          next_deb;
	logic                ev;
	logic                next_ev;
	logic [6:0]          ev_addr;
	logic [6:0]          next_ev_addr;

	always_comb
	begin
		next_addr     = addr;
		next_wait_cnt = wait_cnt;
		next_cmd      = 1'b0;
		next_state    = state;
		next_deb      = deb[addr];
		next_ev       = 1'b0;
		next_ev_addr  = ev_addr;
		if (wait_cnt != 16'h0000)
		begin
			next_wait_cnt = wait_cnt - 16'h0001;
		end
		else
		begin
			// sample after settle, then advance one key
			if (kbd_ret != state[addr])
			begin
				next_deb = deb[addr] + 3'h1;
				if (next_deb == 3'(DEB))
				begin
					next_state[addr] = kbd_ret;
					next_ev          = 1'b1;
					next_ev_addr     = addr;
					next_deb         = 3'h0;
				end
			end
			else
			begin
				next_deb = 3'h0;
			end
			next_addr     = (addr == 7'(KEYS - 1)) ? 7'h00 : addr + 7'h01;
			next_cmd      = 1'b1;
			next_wait_cnt = 16'(WAIT);
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			addr      <= 7'h00;
			wait_cnt  <= 16'h0000;
			cmd       <= 1'b0;
			state     <= '0;
			ev        <= 1'b0;
			ev_addr   <= 7'h00;
			for (int i = 0; i < KEYS; i++)
			begin
				deb[i] <= 3'h0;
			end
		end
		else
		begin
			addr      <= next_addr;
			wait_cnt  <= next_wait_cnt;
			cmd       <= next_cmd;
			state     <= next_state;
			ev        <= next_ev;
			ev_addr   <= next_ev_addr;
			deb[addr] <= next_deb;
		end
	end

	assign kbd_cmd   = cmd;
	assign key_event = ev;
	// report the key that changed, not the one the walker moved on to
	assign key_down  = state[ev_addr];
	assign key_addr  = ev_addr;

	AST_SETTLE: assert property (@(posedge mclk) disable iff (!rst_n)
		kbd_cmd |-> (wait_cnt == 16'(WAIT)))
		else $error("settle wait not loaded after advance");
endmodule

/* src/terminal_io_controller.sv */
// terminal i/o controller: bus glue, port pins and dma lockout
module terminal_io_controller #(
	parameter int WARN_CYC = term_io_pkg::DMA_WARN_CYC
)(
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// core side request
	input  wire term_io_pkg::bus_req_t req,
	output logic                      req_ready,
	output logic [7:0]                rdata,
	output logic                      rdata_valid,
	// multiplexed bus
	input  wire logic [7:0]           ad_in,
	output logic [7:0]                ad_out,
	output logic                      ad_oe,
	output logic [7:0]                addr_hi,
	output logic                      addr_latch_strobe,
	output logic                      program_store_select_n,
	output logic                      wr_strobe_n,
	output logic                      rd_strobe_n,
	// configuration
	input  wire logic                 wide_mode,
	input  wire logic                 dtr_req,
	output logic                      column_select,
	output logic                      aux_dtr_n,
	output logic                      aux_dsr,
	// interrupts and timer pin
	input  wire logic                 dma_warning_request,
	input  wire logic                 peripheral_irq,
	input  wire logic                 timer_zero_input,
	output logic                      external_irq_zero,
	output logic                      external_irq_one,
	output logic                      vsync_start,
	output logic                      dma_lockout,
	// aux and memory serial pins
	input  wire logic                 aux_dsr_n_pin,
	input  wire logic                 nvm_sda_in,
	input  wire logic                 nvm_sda_drive,
	input  wire logic                 nvm_scl_drive,
	output logic                      nvm_sda_out,
	output logic                      nvm_sda_oe,
	output logic                      nvm_scl,
	output logic                      nvm_sda_rd,
	// keyboard
	input  wire logic                 kbd_data,
	output logic                      kbd_command,
	output logic                      key_event,
	output logic                      key_down,
	output logic [6:0]                key_addr
);
	logic        rst_s1;
	logic        rst_s;
	logic [4:0]  s1;
	logic [4:0]  s2;
	logic        tz_prev;
	logic        next_tz_prev;

	// reset release through two flops
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1 <= 1'b0;
			rst_s  <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_s  <= rst_s1;
		end
	end

	// pin synchronisers
	always_ff @(posedge mclk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			// idle levels: dsr inactive high, memory data pulled up
			s1 <= 5'h03;
			s2 <= 5'h03;
		end
		else
		begin
			s1 <= {dma_warning_request, peripheral_irq, timer_zero_input,
				aux_dsr_n_pin, nvm_sda_in};
			s2 <= s1;
		end
	end

	// bus cycle sequencer
	term_io_pkg::space_t   ph;
	term_io_pkg::space_t   next_ph;
	term_io_pkg::bus_req_t cur;
	term_io_pkg::bus_req_t next_cur;
	logic [1:0]            pcnt;
	logic [1:0]            next_pcnt;
	logic [15:0]           warn;
	logic [15:0]           next_warn;
	logic                  lock;
	logic                  next_lock;

	function automatic logic shared_target(input logic [7:0] hi);
		// display ram, video ctrl and modem uart sit in data space
		shared_target = 1'b1;
	endfunction

	always_comb
	begin
		next_ph   = ph;
		next_cur  = cur;
		next_pcnt = pcnt;
		next_warn = warn;
		next_lock = lock;
		next_tz_prev = s2[2];
		// warning opens the lockout window until the request drops
		if (s2[4] && !lock)
		begin
			next_lock = 1'b1;
			next_warn = 16'(WARN_CYC);
		end
		else if (lock && !s2[4])
		begin
			next_lock = 1'b0;
		end
		if (warn != 16'h0000)
		begin
			next_warn = warn - 16'h0001;
		end
		unique case (ph)
			term_io_pkg::SP_IDLE:
			begin
				// data space blocked while dma pending, code fetch allowed
				if (req.valid && !(lock && req.space != term_io_pkg::SP_IDLE
					&& shared_target(req.hi)))
				begin
					next_cur  = req;
					next_ph   = term_io_pkg::SP_ADDR;
					next_pcnt = 2'(term_io_pkg::BUS_PHASE_CYC - 1);
				end
			end
			term_io_pkg::SP_ADDR:
			begin
				if (pcnt == 2'h0)
				begin
					next_ph   = term_io_pkg::SP_DATA;
					next_pcnt = 2'(term_io_pkg::BUS_PHASE_CYC - 1);
				end
				else
				begin
					next_pcnt = pcnt - 2'h1;
				end
			end
			term_io_pkg::SP_DATA:
			begin
				// an access already started finishes
				if (pcnt == 2'h0)
				begin
					next_ph = term_io_pkg::SP_END;
				end
				else
				begin
					next_pcnt = pcnt - 2'h1;
				end
			end
			term_io_pkg::SP_END:
			begin
				next_ph = term_io_pkg::SP_IDLE;
			end
		endcase
	end

	// space encoding in request: SP_IDLE selects program store
	logic       is_code;
	logic       in_addr;
	logic       in_data;
	logic [7:0] next_rdata;
	logic       next_rvalid;
	logic       next_ale;
	logic       next_program_store_select_n;
	logic       next_wr_n;
	logic       next_rd_n;
	logic [7:0] next_ad_out;
	logic       next_ad_oe;
	logic [7:0] next_addr_hi;

	always_comb
	begin
		is_code      = (next_cur.space == term_io_pkg::SP_IDLE);
		in_addr      = (next_ph == term_io_pkg::SP_ADDR);
		in_data      = (next_ph == term_io_pkg::SP_DATA);
		next_ale     = in_addr;
		next_ad_out  = in_addr ? next_cur.lo : next_cur.wdata;
		next_ad_oe   = in_addr || (in_data && next_cur.write && !is_code);
		next_addr_hi = (in_addr || in_data) ? next_cur.hi : addr_hi;
		next_program_store_select_n  = !(in_data && is_code);
		next_wr_n    = !(in_data && !is_code && next_cur.write);
		next_rd_n    = !(in_data && !is_code && !next_cur.write);
		next_rvalid  = (ph == term_io_pkg::SP_DATA) && (pcnt == 2'h0)
			&& !cur.write;
		next_rdata   = next_rvalid ? ad_in : rdata;
	end

	always_ff @(posedge mclk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			ph                     <= term_io_pkg::SP_IDLE;
			cur                    <= '0;
			pcnt                   <= 2'h0;
			warn                   <= 16'h0000;
			lock                   <= 1'b0;
			tz_prev                <= 1'b0;
			addr_latch_strobe      <= 1'b0;
			ad_out                 <= 8'h00;
			ad_oe                  <= 1'b0;
			addr_hi                <= term_io_pkg::RST_ADDR_HI;
			program_store_select_n <= 1'b1;
			wr_strobe_n            <= 1'b1;
			rd_strobe_n            <= 1'b1;
			rdata                  <= 8'h00;
			rdata_valid            <= 1'b0;
			req_ready              <= 1'b0;
		end
		else
		begin
			ph                     <= next_ph;
			cur                    <= next_cur;
			pcnt                   <= next_pcnt;
			warn                   <= next_warn;
			lock                   <= next_lock;
			tz_prev                <= next_tz_prev;
			addr_latch_strobe      <= next_ale;
			ad_out                 <= next_ad_out;
			ad_oe                  <= next_ad_oe;
			addr_hi                <= next_addr_hi;
			program_store_select_n <= next_program_store_select_n;
			wr_strobe_n            <= next_wr_n;
			rd_strobe_n            <= next_rd_n;
			rdata                  <= next_rdata;
			rdata_valid            <= next_rvalid;
			req_ready              <= (next_ph == term_io_pkg::SP_IDLE);
		end
	end

	// port pins
	always_ff @(posedge mclk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			column_select     <= 1'b0;
			aux_dtr_n         <= 1'b1;
			aux_dsr           <= 1'b0;
			external_irq_zero <= 1'b0;
			external_irq_one  <= 1'b0;
			vsync_start       <= 1'b0;
			dma_lockout       <= 1'b0;
			nvm_sda_out       <= 1'b0;
			nvm_sda_oe        <= 1'b0;
			nvm_scl           <= 1'b1;
			nvm_sda_rd        <= 1'b1;
		end
		else
		begin
			column_select     <= wide_mode;
			aux_dtr_n         <= !dtr_req;
			aux_dsr           <= !s2[1];
			external_irq_zero <= s2[4];
			external_irq_one  <= s2[3];
			vsync_start       <= s2[2] && !tz_prev;
			dma_lockout       <= next_lock;
			// open drain data: drive low only
			nvm_sda_out       <= 1'b0;
			nvm_sda_oe        <= !nvm_sda_drive;
			nvm_scl           <= nvm_scl_drive;
			nvm_sda_rd        <= s2[0];
		end
	end

	logic ks_cmd;
	logic ks_ev;
	logic ks_down;
	logic [6:0] ks_addr;
	logic kbd_s1;
	logic kbd_s2;

	always_ff @(posedge mclk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			kbd_s1      <= 1'b0;
			kbd_s2      <= 1'b0;
			kbd_command <= 1'b0;
			key_event   <= 1'b0;
			key_down    <= 1'b0;
			key_addr    <= 7'h00;
		end
		else
		begin
			kbd_s1      <= kbd_data;
			kbd_s2      <= kbd_s1;
			kbd_command <= ks_cmd;
			key_event   <= ks_ev;
			key_down    <= ks_down;
			key_addr    <= ks_addr;
		end
	end

	key_scanner u_keys (
		.mclk      (mclk),
		.rst_n     (rst_s),
		.kbd_cmd   (ks_cmd),
		.kbd_ret   (kbd_s2),
		.key_event (ks_ev),
		.key_down  (ks_down),
		.key_addr  (ks_addr)
	);

	AST_NO_DATA_START_IN_LOCK: assert property (@(posedge mclk)
		disable iff (!rst_s)
		(lock && ph == term_io_pkg::SP_IDLE) |=>
		!(ph == term_io_pkg::SP_ADDR && cur.space != term_io_pkg::SP_IDLE))
		else $error("data access started during dma lockout");
	AST_ALE_LOW_ADDR: assert property (@(posedge mclk) disable iff (!rst_s)
		addr_latch_strobe |-> ad_oe && ad_out == cur.lo)
		else $error("latch strobe without low address on bus");
	AST_PROGRAM_STORE_SELECT_EXCL: assert property (@(posedge mclk) disable iff (!rst_s)
		!program_store_select_n |-> rd_strobe_n && wr_strobe_n)
		else $error("program fetch overlapped io strobe");
	AST_STROBE_EXCL: assert property (@(posedge mclk) disable iff (!rst_s)
		!(~wr_strobe_n && ~rd_strobe_n))
		else $error("read and write strobes together");
	AST_HI_STABLE: assert property (@(posedge mclk) disable iff (!rst_s)
		addr_latch_strobe |=> addr_hi == $past(addr_hi))
		else $error("upper address moved during access");
	AST_IRQ0_FOLLOW: assert property (@(posedge mclk) disable iff (!rst_s)
		$rose(s2[4]) |=> external_irq_zero ##1 dma_lockout)
		else $error("warning not passed to irq zero and lockout");
	AST_COLUMN: assert property (@(posedge mclk) disable iff (!rst_s)
		##1 column_select == $past(wide_mode))
		else $error("column select does not follow mode");
	AST_IRQ1: assert property (@(posedge mclk) disable iff (!rst_s)
		external_irq_one == $past(s2[3]))
		else $error("irq one does not follow uart request");
endmodule

/* testbench/far_side_model.sv */
// far side: memory on the bus, keyboard scanner, config memory line
module far_side_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// multiplexed bus
	input  wire logic [7:0] ad_out,
	input  wire logic [7:0] addr_hi,
	input  wire logic       addr_latch_strobe,
	input  wire logic       program_store_select_n,
	input  wire logic       wr_strobe_n,
	input  wire logic       rd_strobe_n,
	output logic [7:0]      ad_in,
	// keyboard link
	input  wire logic       kbd_command,
	input  wire logic       press,
	input  wire logic [6:0] press_key,
	output logic            kbd_data,
	// config memory line
	input  wire logic       nvm_sda_out,
	input  wire logic       nvm_sda_oe,
	input  wire logic       mem_pull,
	output logic            nvm_sda_in
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0]  dmem [0:65535];
	logic [7:0]  lo_lat;
	logic [7:0]  last_ad;
	logic [6:0]  key_cnt;
	logic [15:0] addr;

	assign addr = {addr_hi, lo_lat};

	// program store has its own contents; undriven bus keeps changing
	always_comb
	begin
		if (!program_store_select_n)
			ad_in = addr[15:8] ^ addr[7:0] ^ 8'h5A;
		else if (!rd_strobe_n)
			ad_in = dmem[addr];
		else
			ad_in = ~last_ad;
	end

	always @(posedge mclk)
	begin
		last_ad <= ad_in;
		if (addr_latch_strobe)
			lo_lat <= ad_out;
		if (!wr_strobe_n)
			dmem[addr] <= ad_out;
	end

	// row/column counter steps on each command pulse
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			key_cnt <= 7'h00;
		else if (kbd_command)
			key_cnt <= (key_cnt == 7'h67) ? 7'h00 : key_cnt + 7'h01;
	end

	assign kbd_data = press && key_cnt == press_key;
	// pulled-up line, low if either side pulls
	assign nvm_sda_in = !((nvm_sda_oe && !nvm_sda_out) || mem_pull);
endmodule

/* testbench/terminal_io_controller_test.sv */
// testbench: bus cycles, pins, dma lockout and key scan
module terminal_io_controller_test;
	timeunit 1ns;
	timeprecision 1ps;

	term_io_pkg::bus_req_t req;
	logic mclk, rst_n, req_ready, rdata_valid, ad_oe, addr_latch_strobe;
	logic program_store_select_n, wr_strobe_n, rd_strobe_n;
	logic wide_mode, dtr_req, column_select, aux_dtr_n, aux_dsr;
	logic dma_warning_request, peripheral_irq, timer_zero_input;
	logic external_irq_zero, external_irq_one, vsync_start, dma_lockout;
	logic aux_dsr_n_pin, nvm_sda_in, nvm_sda_drive, nvm_scl_drive;
	logic nvm_sda_out, nvm_sda_oe, nvm_scl, nvm_sda_rd, mem_pull;
	logic kbd_data, kbd_command, key_event, key_down, press, seen;
	logic [7:0] rdata, ad_in, ad_out, addr_hi;
	logic [6:0] key_addr, press_key;
	int fails, compares, gap, n;

	terminal_io_controller i_terminal_io_controller (.mclk, .rst_n, .req,
		.req_ready, .rdata, .rdata_valid, .ad_in, .ad_out, .ad_oe, .addr_hi,
		.addr_latch_strobe, .program_store_select_n, .wr_strobe_n,
		.rd_strobe_n, .wide_mode, .dtr_req, .column_select, .aux_dtr_n,
		.aux_dsr, .dma_warning_request, .peripheral_irq, .timer_zero_input,
		.external_irq_zero, .external_irq_one, .vsync_start, .dma_lockout,
		.aux_dsr_n_pin, .nvm_sda_in, .nvm_sda_drive, .nvm_scl_drive,
		.nvm_sda_out, .nvm_sda_oe, .nvm_scl, .nvm_sda_rd, .kbd_data,
		.kbd_command, .key_event, .key_down, .key_addr);

	far_side_model i_far_side_model (.mclk, .rst_n, .ad_out, .addr_hi,
		.addr_latch_strobe, .program_store_select_n, .wr_strobe_n,
		.rd_strobe_n, .ad_in, .kbd_command, .press, .press_key, .kbd_data,
		.nvm_sda_out, .nvm_sda_oe, .mem_pull, .nvm_sda_in);

	always #20 mclk = ~mclk;

	task automatic end_sim();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic step(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask

	// bounded wait for a flag, which then must be high
	task automatic wait_for(ref logic flag, input int lim);
		int k;
		k = 0;
		while (flag !== 1'h1 && k < lim)
		begin
			step(1);
			k++;
		end
		if (flag !== 1'h1)
		begin
			fails++;
			end_sim();
		end
	endtask

	task automatic access(input logic wr, input term_io_pkg::space_t sp,
		input logic [15:0] a, input logic [7:0] wd, input logic [7:0] exp);
		logic dat;
		dat = sp != term_io_pkg::SP_IDLE;
		wait_for(req_ready, 20);
		req = '{1'h1, wr, sp, a[15:8], a[7:0], wd};
		step(1);
		req.valid = 1'h0;
		step(1);
		check(addr_latch_strobe, 1'h1);
		check(ad_out, a[7:0]);
		check(ad_oe, 1'h1);
		check(addr_hi, a[15:8]);
		step(2);
		check(wr_strobe_n, !(wr && dat));
		check(rd_strobe_n, !(!wr && dat));
		check(program_store_select_n, dat);
		check(addr_hi, a[15:8]);
		if (wr)
			check(ad_out, wd);
		step(1);
		check(wr_strobe_n, 1'h1);
		check(rd_strobe_n, 1'h1);
		check(rdata_valid, !wr);
		if (!wr)
			check(rdata, exp);
	endtask

	// spacing of key address steps
	always @(negedge mclk)
	begin
		gap = gap + 1;
		if (kbd_command === 1'h1)
		begin
			if (seen)
				check(gap >= term_io_pkg::KEY_SETTLE_CYC, 1'h1);
			seen = 1'h1;
			gap = 0;
		end
	end

	initial
	begin
		{mclk, rst_n, wide_mode, dtr_req, peripheral_irq, mem_pull} = '0;
		{dma_warning_request, timer_zero_input, seen, nvm_scl_drive} = '0;
		{aux_dsr_n_pin, nvm_sda_drive} = 2'h3;
		req = '0;
		press = 1'h1;
		press_key = 7'h05;
		{fails, compares, gap} = '0;
		step(4);
		check(wr_strobe_n & rd_strobe_n & program_store_select_n, 1'h1);
		check(ad_oe, 1'h0);
		rst_n = 1'h1;
		access(1'h1, term_io_pkg::SP_DATA, 16'h1234, 8'hA5, 8'h00);
		access(1'h1, term_io_pkg::SP_ADDR, 16'hFFFF, 8'h3C, 8'h00);
		access(1'h0, term_io_pkg::SP_END, 16'h1234, 8'h00, 8'hA5);
		access(1'h0, term_io_pkg::SP_DATA, 16'hFFFF, 8'h00, 8'h3C);
		access(1'h0, term_io_pkg::SP_IDLE, 16'h1234, 8'h00, 8'h7C);
		for (int v = 0; v < 2; v++)
		begin
			{wide_mode, dtr_req, aux_dsr_n_pin, peripheral_irq} = {4{v[0]}};
			{nvm_sda_drive, nvm_scl_drive} = {2{v[0]}};
			step(5);
			check(column_select, v[0]);
			check(aux_dtr_n, !v[0]);
			check(aux_dsr, !v[0]);
			check(external_irq_one, v[0]);
			check(nvm_scl, v[0]);
			check(nvm_sda_oe, !v[0]);
			check(nvm_sda_rd, v[0]);
		end
		mem_pull = 1'h1;
		step(5);
		check(nvm_sda_rd, 1'h0);
		timer_zero_input = 1'h1;
		wait_for(vsync_start, 6);
		dma_warning_request = 1'h1;
		wait_for(dma_lockout, 6);
		check(external_irq_zero, 1'h1);
		req = '{1'h1, 1'h0, term_io_pkg::SP_DATA, 8'h12, 8'h34, 8'h00};
		for (int k = 0; k < 8; k++)
		begin
			step(1);
			check(rd_strobe_n | addr_latch_strobe, 1'h1);
			check(req_ready, 1'h1);
		end
		req.valid = 1'h0;
		step(1);
		access(1'h0, term_io_pkg::SP_IDLE, 16'h0102, 8'h00, 8'h59);
		dma_warning_request = 1'h0;
		step(5);
		check(dma_lockout, 1'h0);
		access(1'h0, term_io_pkg::SP_DATA, 16'h1234, 8'h00, 8'hA5);
		n = 0;
		while (!(key_event === 1'h1 && key_down === 1'h1) && n < 90000)
		begin
			step(1);
			n++;
		end
		check(n < 90000, 1'h1);
		check(key_addr, 7'h05);
		end_sim();
	end
endmodule
